// ==== src/cpld_macrocell.sv ====
// Behaviour
// - Four dedicated inputs: clock, clear, two enables.
// - Five product terms per macrocell.
// - Each term routes to logic or register controls.
// - Shareable inverted feedback; parallel terms borrowed.
// - Register acts as D, T, JK or SR.
// - Register bypass drives combinational result out.
// - Clock from global, gated global or array.
// - Gated mode updates only when enable high.
// - Array clock term sees buried cells, pins.
// - Two clock nets, true or inverted pins.
// - Term preset and clear, active high, asynchronous.
// - Optional global clear pin, active low.
// - Enhanced variant powers up high or low.
// - Other variants power up low.
// - Fast pin path straight into register.
// - Pin direction via enable: off, on, global.
// - Six global enable nets with selectable sources.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module cpld_macrocell #(
	parameter bit ENHANCED = 1'b1,
	parameter bit POWERUP_HIGH = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [cpld_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [cpld_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [3:0] ded_in,
	input wire logic io_pin_in,
	output logic io_pin_out,
	output logic io_pin_oe,
	input wire logic [3:0] array_in,
	input wire logic par_exp_in,
	input wire logic share_exp_in,
	output logic share_exp_out,
	output logic cell_out
);

	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic [1:0] rst_sync_q;
	logic rst_n_int;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync_q[1];

	logic [cpld_pkg::SYNC_W-1:0] pin_s;
	logic [3:0] ded_s;
	logic io_s;

	pin_sync3 u_sync (
		.sys_clk(sys_clk),
		.rst_n_int(rst_n_int),
		.pin_raw({io_pin_in, ded_in}),
		.pin_clean(pin_s)
	);
	assign ded_s = pin_s[3:0];
	assign io_s = pin_s[cpld_pkg::SYNC_IO];

	cpld_pkg::cell_state_type s_q;
	cpld_pkg::cell_state_type s_d;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] wr_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] pt_ofs(input int i);
		return cpld_pkg::OFS_PT0 + 8'(i) * cpld_pkg::OFS_STEP;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		logic ok;
		ok = (a == cpld_pkg::OFS_CTRL) || (a == cpld_pkg::OFS_CLK) ||
			(a == cpld_pkg::OFS_ROLE) || (a == cpld_pkg::OFS_IO) ||
			(a == cpld_pkg::OFS_GOE) || (a == cpld_pkg::OFS_STATUS);
		for (int i = 0; i < cpld_pkg::PT_N; i++) begin
			ok = ok | (a == pt_ofs(i));
		end
		return ok;
	endfunction

	function automatic cpld_pkg::role_type role_of(input logic [31:0] w,
		input int i);
		return cpld_pkg::role_type'(w[i*cpld_pkg::ROLE_W +: cpld_pkg::ROLE_W]);
	endfunction

	function automatic logic pick(input logic [cpld_pkg::PT_N-1:0] v,
		input logic [2:0] idx);
		return (32'(idx) < cpld_pkg::PT_N) ? v[idx] : 1'b0;
	endfunction

	// ****************************************
	// Product terms
	// ****************************************
	logic [cpld_pkg::LIT_W-1:0] lit;
	logic [cpld_pkg::PT_N-1:0] pt;
	logic [cpld_pkg::PT_N-1:0] is_logic;
	logic [cpld_pkg::PT_N-1:0] is_preset;
	logic [cpld_pkg::PT_N-1:0] is_clear;
	logic [cpld_pkg::PT_N-1:0] is_clock;

	// Terms see array inputs, dedicated inputs, the pin, the cell itself
	// and a shareable expander from a neighbour.
	assign lit = {share_exp_in, s_q.q, io_s, ded_s, array_in};

	genvar gi;
	generate
		for (gi = 0; gi < cpld_pkg::PT_N; gi++) begin : g_pt
			logic [cpld_pkg::LIT_W-1:0] tm;
			logic [cpld_pkg::LIT_W-1:0] cm;
			assign tm = s_q.pt[gi][cpld_pkg::PT_TRUE_LSB +: cpld_pkg::LIT_W];
			assign cm = s_q.pt[gi][cpld_pkg::PT_COMP_LSB +: cpld_pkg::LIT_W];
			assign pt[gi] = &(lit | ~tm) & &(~lit | ~cm);
			assign is_logic[gi] =
				role_of(s_q.role, gi) == cpld_pkg::ROLE_LOGIC;
			assign is_preset[gi] = role_of(s_q.role, gi) == cpld_pkg::ROLE_PRESET;
			assign is_clear[gi] = role_of(s_q.role, gi) == cpld_pkg::ROLE_CLEAR;
			assign is_clock[gi] = role_of(s_q.role, gi) == cpld_pkg::ROLE_CLOCK;
		end
	endgenerate

	// ****************************************
	// Cell logic
	// ****************************************
	cpld_pkg::ff_kind_type ff_kind;
	cpld_pkg::clk_mode_type clk_mode;
	logic sum_or;
	logic comb;
	logic aux;
	logic d_in;
	logic preset;
	logic clear;
	logic net0;
	logic net1;
	logic gnet;
	logic clk_term;
	logic clk_src;
	logic clk_edge;
	logic clk_en;
	logic ff_next;

	assign ff_kind = cpld_pkg::ff_kind_type'(s_q.ctrl[cpld_pkg::CTRL_FT_LSB +: 2]);
	assign clk_mode =
		cpld_pkg::clk_mode_type'(s_q.ctrl[cpld_pkg::CTRL_CLKM_LSB +: 2]);
	assign sum_or = |(pt & is_logic) |
		(s_q.ctrl[cpld_pkg::CTRL_PEXP] & par_exp_in);
	assign comb = sum_or ^ s_q.ctrl[cpld_pkg::CTRL_XOR];
	assign share_exp_out =
		~pick(pt, s_q.ctrl[cpld_pkg::CTRL_SHR_LSB +: 3]);
	assign aux = pick(pt, s_q.ctrl[cpld_pkg::CTRL_AUX_LSB +: 3]);
	assign d_in = s_q.ctrl[cpld_pkg::CTRL_FAST] ? io_s : comb;
	assign preset = |(pt & is_preset);
	assign clear = |(pt & is_clear) | (s_q.ctrl[cpld_pkg::CTRL_GCLR] &
		~ded_s[cpld_pkg::DED_CLR_N]);

	assign net0 = (s_q.clkc[cpld_pkg::CLK_N0_PIN] ? ded_s[cpld_pkg::DED_OE_B] :
		ded_s[cpld_pkg::DED_CLK_A]) ^ s_q.clkc[cpld_pkg::CLK_N0_INV];
	assign net1 = (s_q.clkc[cpld_pkg::CLK_N1_PIN] ? ded_s[cpld_pkg::DED_OE_B] :
		ded_s[cpld_pkg::DED_CLK_A]) ^ s_q.clkc[cpld_pkg::CLK_N1_INV];
	assign gnet = s_q.clkc[cpld_pkg::CLK_NET_SEL] ? net1 : net0;
	assign clk_term = |(pt & is_clock);
	assign clk_src = (clk_mode == cpld_pkg::CLK_ARRAY) ? clk_term : gnet;
	assign clk_edge = clk_src & ~s_q.clk_prev;
	assign clk_en = (clk_mode == cpld_pkg::CLK_GATED) ? clk_term : 1'b1;

	always_comb begin
		unique case (ff_kind)
			cpld_pkg::FF_D: ff_next = d_in;
			cpld_pkg::FF_T: ff_next = s_q.q ^ d_in;
			cpld_pkg::FF_JK: ff_next = (d_in & ~s_q.q) | (~aux & s_q.q);
			cpld_pkg::FF_SR: ff_next = d_in | (~aux & s_q.q);
		endcase
	end

	// ****************************************
	// Global output enables
	// ****************************************
	logic [cpld_pkg::GOE_N-1:0] goe_net;
	cpld_pkg::oe_src_type oe_src;
	logic [2:0] goe_idx;
	logic oe_now;

	generate
		for (gi = 0; gi < cpld_pkg::GOE_N; gi++) begin : g_goe
			cpld_pkg::goe_src_type src;
			assign src = cpld_pkg::goe_src_type'(
				s_q.goe[gi*cpld_pkg::GOE_W +: 3]);
			always_comb begin
				case (src)
					cpld_pkg::GOE_A: goe_net[gi] = ded_s[cpld_pkg::DED_OE_A];
					cpld_pkg::GOE_A_N: goe_net[gi] = ~ded_s[cpld_pkg::DED_OE_A];
					cpld_pkg::GOE_B: goe_net[gi] = ded_s[cpld_pkg::DED_OE_B];
					cpld_pkg::GOE_B_N: goe_net[gi] = ~ded_s[cpld_pkg::DED_OE_B];
					cpld_pkg::GOE_PIN: goe_net[gi] = io_s;
					cpld_pkg::GOE_CELL: goe_net[gi] = s_q.out;
					default: goe_net[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	assign oe_src = cpld_pkg::oe_src_type'(s_q.ioc[cpld_pkg::IO_OE_LSB +: 2]);
	assign goe_idx = s_q.ioc[cpld_pkg::IO_GOE_LSB +: 3];

	always_comb begin
		case (oe_src)
			cpld_pkg::OE_VCC: oe_now = 1'b1;
			cpld_pkg::OE_GLOBAL:
				oe_now = (32'(goe_idx) < cpld_pkg::GOE_N) ? goe_net[goe_idx] : 1'b0;
			default: oe_now = 1'b0;
		endcase
	end

	// ****************************************
	// Bus slave and state update
	// ****************************************
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic have_aw;
	logic have_w;
	logic [7:0] waddr;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [31:0] status;

	assign awready = ~s_q.aw_full & ~s_q.bvalid;
	assign wready = ~s_q.w_full & ~s_q.bvalid;
	assign arready = ~s_q.rvalid;
	assign aw_hs = awvalid & awready;
	assign w_hs = wvalid & wready;
	assign ar_hs = arvalid & arready;
	assign have_aw = s_q.aw_full | aw_hs;
	assign have_w = s_q.w_full | w_hs;
	assign waddr = s_q.aw_full ? s_q.aw_addr : awaddr;
	assign wd = s_q.w_full ? s_q.w_data : wdata;
	assign ws = s_q.w_full ? s_q.w_strb : wstrb;
	assign status = {24'h00_0000, s_q.oe, gnet, clk_term, io_s, aux, comb,
		s_q.out, s_q.q};

	always_comb begin
		s_d = s_q;
		if (have_aw && have_w) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = addr_ok(waddr) ? cpld_pkg::RESP_OKAY :
				cpld_pkg::RESP_SLVERR;
			case (waddr)
				cpld_pkg::OFS_CTRL: s_d.ctrl = wr_merge(s_q.ctrl, wd, ws);
				cpld_pkg::OFS_CLK: s_d.clkc = wr_merge(s_q.clkc, wd, ws);
				cpld_pkg::OFS_ROLE: s_d.role = wr_merge(s_q.role, wd, ws);
				cpld_pkg::OFS_IO: s_d.ioc = wr_merge(s_q.ioc, wd, ws);
				cpld_pkg::OFS_GOE: s_d.goe = wr_merge(s_q.goe, wd, ws);
				default: ;
			endcase
			for (int i = 0; i < cpld_pkg::PT_N; i++) begin
				if (waddr == pt_ofs(i)) begin
					s_d.pt[i] = wr_merge(s_q.pt[i], wd, ws);
				end
			end
		end else begin
			if (aw_hs) begin
				s_d.aw_full = 1'b1;
				s_d.aw_addr = awaddr;
			end
			if (w_hs) begin
				s_d.w_full = 1'b1;
				s_d.w_data = wdata;
				s_d.w_strb = wstrb;
			end
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (ar_hs) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = addr_ok(araddr) ? cpld_pkg::RESP_OKAY :
				cpld_pkg::RESP_SLVERR;
			s_d.rdata = 32'h0000_0000;
			case (araddr)
				cpld_pkg::OFS_CTRL: s_d.rdata = s_q.ctrl;
				cpld_pkg::OFS_CLK: s_d.rdata = s_q.clkc;
				cpld_pkg::OFS_ROLE: s_d.rdata = s_q.role;
				cpld_pkg::OFS_IO: s_d.rdata = s_q.ioc;
				cpld_pkg::OFS_GOE: s_d.rdata = s_q.goe;
				cpld_pkg::OFS_STATUS: s_d.rdata = status;
				default: ;
			endcase
			for (int i = 0; i < cpld_pkg::PT_N; i++) begin
				if (araddr == pt_ofs(i)) begin
					s_d.rdata = s_q.pt[i];
				end
			end
		end else if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end

		s_d.clk_prev = clk_src;
		// Reset can only load a constant, so the configured power-up level
		// is applied in the first cycle after release.
		unique case (s_q.phase)
			cpld_pkg::PH_POWERUP: begin
				s_d.q = ENHANCED & POWERUP_HIGH;
				s_d.phase = cpld_pkg::PH_RUN;
			end
			cpld_pkg::PH_RUN: begin
				if (clear) begin
					s_d.q = 1'b0;
				end else if (preset) begin
					s_d.q = 1'b1;
				end else if (clk_edge && clk_en) begin
					s_d.q = ff_next;
				end
			end
			default: s_d.phase = cpld_pkg::PH_POWERUP;
		endcase
		s_d.out = s_q.ctrl[cpld_pkg::CTRL_BYP] ? comb : s_d.q;
		s_d.oe = oe_now;
	end

	always_ff @(posedge sys_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			s_q <= '{phase: cpld_pkg::PH_POWERUP, ctrl: cpld_pkg::CFG_RST,
				clkc: cpld_pkg::CFG_RST, role: cpld_pkg::CFG_RST,
				ioc: cpld_pkg::CFG_RST, goe: cpld_pkg::CFG_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign cell_out = s_q.out;
	assign io_pin_out = s_q.out;
	assign io_pin_oe = s_q.oe;

endmodule

`default_nettype wire

// ==== shared/cpld_pkg.sv ====
package cpld_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int LIT_W = 11;
	localparam int PT_N = 5;
	localparam int GOE_N = 6;
	localparam int SYNC_W = 5;
	localparam int ADDR_W = 8;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLK = 8'h04;
	localparam logic [7:0] OFS_ROLE = 8'h08;
	localparam logic [7:0] OFS_IO = 8'h0c;
	localparam logic [7:0] OFS_GOE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_PT0 = 8'h20;
	localparam logic [7:0] OFS_STEP = 8'h04;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_FT_LSB = 0;
	localparam int CTRL_BYP = 2;
	localparam int CTRL_CLKM_LSB = 3;
	localparam int CTRL_GCLR = 5;
	localparam int CTRL_XOR = 6;
	localparam int CTRL_PEXP = 7;
	localparam int CTRL_FAST = 8;
	localparam int CTRL_AUX_LSB = 12;
	localparam int CTRL_SHR_LSB = 16;
	localparam int CLK_N0_PIN = 0;
	localparam int CLK_N0_INV = 1;
	localparam int CLK_N1_PIN = 2;
	localparam int CLK_N1_INV = 3;
	localparam int CLK_NET_SEL = 4;
	localparam int ROLE_W = 2;
	localparam int IO_OE_LSB = 0;
	localparam int IO_GOE_LSB = 4;
	localparam int GOE_W = 4;
	localparam int PT_TRUE_LSB = 0;
	localparam int PT_COMP_LSB = 16;

	// ****************************************
	// Dedicated inputs and pin sync slots
	// ****************************************
	localparam int DED_CLK_A = 0;
	localparam int DED_CLR_N = 1;
	localparam int DED_OE_A = 2;
	localparam int DED_OE_B = 3;
	localparam int SYNC_IO = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		FF_D = 2'h0, FF_T = 2'h1, FF_JK = 2'h2, FF_SR = 2'h3
	} ff_kind_type;
	typedef enum logic [1:0] {
		CLK_GLOBAL = 2'h0, CLK_GATED = 2'h1, CLK_ARRAY = 2'h2
	} clk_mode_type;
	typedef enum logic [1:0] {
		ROLE_LOGIC = 2'h0, ROLE_PRESET = 2'h1, ROLE_CLEAR = 2'h2,
		ROLE_CLOCK = 2'h3
	} role_type;
	typedef enum logic [1:0] {
		OE_GND = 2'h0, OE_VCC = 2'h1, OE_GLOBAL = 2'h2
	} oe_src_type;
	typedef enum logic [2:0] {
		GOE_A = 3'h0, GOE_A_N = 3'h1, GOE_B = 3'h2, GOE_B_N = 3'h3,
		GOE_PIN = 3'h4, GOE_CELL = 3'h5
	} goe_src_type;
	typedef enum logic [1:0] {
		PH_POWERUP = 2'b01, PH_RUN = 2'b10
	} phase_type;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] clean;
	} sync_state_type;

	typedef struct packed {
		phase_type phase;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] ctrl;
		logic [31:0] clkc;
		logic [31:0] role;
		logic [31:0] ioc;
		logic [31:0] goe;
		logic [PT_N-1:0][31:0] pt;
		logic clk_prev;
		logic q;
		logic out;
		logic oe;
	} cell_state_type;

endpackage

// ==== src/pin_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
	input wire logic sys_clk,
	input wire logic rst_n_int,
	input wire logic [cpld_pkg::SYNC_W-1:0] pin_raw,
	output logic [cpld_pkg::SYNC_W-1:0] pin_clean
);

	cpld_pkg::sync_state_type s_q;
	cpld_pkg::sync_state_type s_d;

	// The clean copy only moves when the second and third stages agree,
	// which filters one-cycle glitches caught near a sampling edge.
	always_comb begin
		s_d = s_q;
		s_d.s1 = pin_raw;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		s_d.clean = (s_q.s2 & s_q.s3) | (s_q.clean & (s_q.s2 ^ s_q.s3));
	end

	always_ff @(posedge sys_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_clean = s_q.clean;

endmodule

`default_nettype wire

// ==== dv/cpld_macrocell_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpld_macrocell_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready
);
	// ****************************************
	// Register bus answers
	// ****************************************
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer changed before it was taken");
	a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer changed before it was taken");
	a_write_answer: assert property (awvalid && awready && wvalid && wready
		|=> bvalid)
		else $error("write answer late");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	a_read_refused: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_b_release: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer not released");
	a_r_release: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer not released");
endmodule

bind cpld_macrocell cpld_macrocell_asserts i_cpld_macrocell_asserts (
	.sys_clk(sys_clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready));

`default_nettype wire

// ==== dv/cell_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module cell_partner (
	input wire logic [3:0] ded_set,
	input wire logic [3:0] arr_set,
	input wire logic [3:0] misc,
	input wire logic io_pin_out,
	input wire logic io_pin_oe,
	output logic [3:0] ded_in,
	output logic io_pin_in,
	output logic [3:0] array_in,
	output logic par_exp_in,
	output logic share_exp_in
);
	logic drv;
	logic last = 1'b0;

	// ****************************************
	// Pins and neighbours
	// ****************************************
	// The pin has no pull, so once released it shows the inverse level.
	assign drv = io_pin_oe ? io_pin_out : misc[0];
	always @* begin
		if (io_pin_oe || misc[1]) last = drv;
	end
	assign io_pin_in = (io_pin_oe || misc[1]) ? drv : ~last;
	assign ded_in = ded_set;
	assign array_in = arr_set;
	assign par_exp_in = misc[2];
	assign share_exp_in = misc[3];
endmodule

`default_nettype wire

// ==== dv/test_cpld_macrocell.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

module test_cpld_macrocell;
	logic sys_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, io_pin_in, io_pin_out, io_pin_oe;
	logic par_exp_in, share_exp_in, share_exp_out, cell_out, slow;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, ded_set, arr_set, misc, ded_in, array_in;
	logic [1:0] bresp, rresp, r;
	int n_mismatch = 0;
	int num_checks = 0;

	cpld_macrocell #(.ENHANCED(1'b1), .POWERUP_HIGH(1'b1)) i_cpld_macrocell (
		.sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .ded_in(ded_in),
		.io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
		.array_in(array_in), .par_exp_in(par_exp_in),
		.share_exp_in(share_exp_in), .share_exp_out(share_exp_out),
		.cell_out(cell_out));
	cell_partner i_cell_partner (.ded_set(ded_set), .arr_set(arr_set),
		.misc(misc), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
		.ded_in(ded_in), .io_pin_in(io_pin_in), .array_in(array_in),
		.par_exp_in(par_exp_in), .share_exp_in(share_exp_in));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Bus and pin helpers
	// ****************************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The ready is raised late in slow mode so that answers must stand.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tv;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		repeat (40) begin
			@(negedge sys_clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tv = bvalid;
			r = bresp;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tv && bready) begin
				bready <= 1'b0;
				return;
			end else if (tv) bready <= 1'b1;
		end
		n_mismatch++;
		final_report;
	endtask

	task automatic rd(input logic [7:0] a);
		logic ta, tv;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !slow;
		repeat (40) begin
			@(negedge sys_clk);
			ta = arvalid & arready;
			tv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk);
			if (ta) arvalid <= 1'b0;
			if (tv && rready) begin
				rready <= 1'b0;
				return;
			end else if (tv) rready <= 1'b1;
		end
		n_mismatch++;
		final_report;
	endtask

	task automatic wt(input bit s, input logic e);
		logic v;
		repeat (40) begin
			@(negedge sys_clk);
			v = s ? io_pin_oe : cell_out;
			if (v === e) break;
		end
		`CHK(v, e)
	endtask

	// Twelve cycles cover the pin synchroniser, edge detect and output flop.
	task automatic tog(input int b);
		@(posedge sys_clk);
		ded_set[b] <= ~ded_set[b];
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic pulse(input int b);
		tog(b);
		tog(b);
	endtask

	task automatic arr(input logic [3:0] v);
		@(posedge sys_clk);
		arr_set <= v;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic pt(input int i, input logic [31:0] v);
		wr(cpld_pkg::OFS_PT0 + 8'(4 * i), v);
	endtask

	// A term holding a literal and its complement is always false.
	task automatic clean;
		for (int i = 0; i < cpld_pkg::PT_N; i++) pt(i, 32'h0001_0001);
		wr(cpld_pkg::OFS_ROLE, 32'h0);
		pt(0, 32'h1);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_bus;
		slow = 1'b1;
		rd(cpld_pkg::OFS_CTRL);
		`CHK(d, cpld_pkg::CFG_RST)
		wr(8'h18, 32'h1);
		`CHK(r, cpld_pkg::RESP_SLVERR)
		rd(8'h18);
		`CHK({r, d}, {cpld_pkg::RESP_SLVERR, 32'h0})
		wr(cpld_pkg::OFS_STATUS, 32'hff);
		`CHK(r, cpld_pkg::RESP_OKAY)
		pt(4, 32'h0001_0001);
		wstrb <= 4'h2;
		pt(4, 32'hffff_ffff);
		wstrb <= 4'hf;
		rd(cpld_pkg::OFS_PT0 + 8'h10);
		`CHK({r, d}, {cpld_pkg::RESP_OKAY, 32'h0001_ff01})
		slow = 1'b0;
		$display("bus test done");
	endtask

	task automatic t_comb;
		clean;
		wr(cpld_pkg::OFS_CTRL, 32'h4);
		arr(4'h1);
		wt(0, 1'b1);
		`CHK(share_exp_out, 1'b0)
		arr(4'h0);
		wt(0, 1'b0);
		`CHK(share_exp_out, 1'b1)
		@(posedge sys_clk);
		misc <= 4'h4;
		wr(cpld_pkg::OFS_CTRL, 32'h84);
		wt(0, 1'b1);
		@(posedge sys_clk);
		misc <= 4'h0;
		wr(cpld_pkg::OFS_CTRL, 32'h44);
		wt(0, 1'b1);
		wr(cpld_pkg::OFS_CTRL, 32'h4);
		pt(0, 32'h400);
		@(posedge sys_clk);
		misc <= 4'h8;
		wt(0, 1'b1);
		@(posedge sys_clk);
		misc <= 4'h0;
		wt(0, 1'b0);
		$display("logic test done");
	endtask

	task automatic t_kinds;
		logic [3:0] e2, e3;
		e2 = 4'b1101;
		e3 = 4'b1011;
		clean;
		pt(1, 32'h2);
		for (int k = 0; k < 4; k++) begin
			wr(cpld_pkg::OFS_CTRL, 32'h0);
			arr(4'h0);
			pulse(0);
			wr(cpld_pkg::OFS_CTRL, 32'h1000 | k);
			arr(4'h1);
			`CHK(cell_out, 1'b0)
			pulse(0);
			wt(0, 1'b1);
			pulse(0);
			wt(0, e2[k]);
			arr(4'h3);
			pulse(0);
			wt(0, e3[k]);
		end
		$display("register kind test done");
	endtask

	task automatic t_clocks;
		clean;
		wr(cpld_pkg::OFS_CTRL, 32'h0);
		wr(cpld_pkg::OFS_CLK, 32'h2);
		arr(4'h0);
		tog(0);
		`CHK(cell_out, 1'b1)
		tog(0);
		wt(0, 1'b0);
		wr(cpld_pkg::OFS_CLK, 32'h14);
		arr(4'h1);
		pulse(3);
		wt(0, 1'b1);
		wr(cpld_pkg::OFS_CLK, 32'h0);
		wr(cpld_pkg::OFS_CTRL, 32'h100);
		@(posedge sys_clk);
		misc <= 4'h2;
		pulse(0);
		wt(0, 1'b0);
		@(posedge sys_clk);
		misc <= 4'h3;
		pulse(0);
		wt(0, 1'b1);
		wr(cpld_pkg::OFS_CTRL, 32'h10);
		pt(1, 32'h100);
		wr(cpld_pkg::OFS_ROLE, 32'hc);
		arr(4'h0);
		@(posedge sys_clk);
		misc <= 4'h2;
		repeat (12) @(posedge sys_clk);
		misc <= 4'h3;
		wt(0, 1'b0);
		$display("clock test done");
	endtask

	task automatic t_async;
		clean;
		pt(1, 32'h2);
		pt(2, 32'h4);
		pt(3, 32'h8);
		wr(cpld_pkg::OFS_ROLE, 32'h6c);
		wr(cpld_pkg::OFS_CTRL, 32'h8);
		arr(4'h8);
		wt(0, 1'b1);
		arr(4'h0);
		pulse(0);
		`CHK(cell_out, 1'b1)
		arr(4'h2);
		pulse(0);
		wt(0, 1'b0);
		arr(4'hc);
		wt(0, 1'b0);
		arr(4'h8);
		arr(4'h0);
		wr(cpld_pkg::OFS_CTRL, 32'h28);
		tog(1);
		wt(0, 1'b0);
		arr(4'h8);
		wt(0, 1'b0);
		tog(1);
		wt(0, 1'b1);
		$display("preset and clear test done");
	endtask

	task automatic t_io;
		int ord[6];
		logic [5:0] e;
		ord = '{0, 1, 4, 2, 3, 5};
		e = 6'b110001;
		@(posedge sys_clk);
		misc <= 4'h0;
		ded_set <= 4'b0110;
		wt(1, 1'b0);
		wr(cpld_pkg::OFS_IO, 32'h1);
		wt(1, 1'b1);
		wr(cpld_pkg::OFS_IO, 32'h62);
		wt(1, 1'b0);
		wr(cpld_pkg::OFS_IO, 32'h2);
		for (int i = 0; i < 6; i++) begin
			wr(cpld_pkg::OFS_GOE, 32'(ord[i]));
			wt(1, e[i]);
		end
		`CHK(io_pin_out, 1'b1)
		$display("pin enable test done");
	endtask

	// A reset in mid-run must drop the outputs and reload power-up state.
	task automatic t_reset;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK({cell_out, io_pin_oe}, 2'b00)
		@(posedge sys_clk);
		rstn <= 1'b1;
		wt(0, 1'b1);
		rd(cpld_pkg::OFS_IO);
		`CHK({r, d}, {cpld_pkg::RESP_OKAY, cpld_pkg::CFG_RST})
		$display("reset test done");
	endtask

	initial begin
		rstn = 1'b0;
		slow = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		ded_set = 4'b0010;
		arr_set = 4'h0;
		misc = 4'h0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		wt(0, 1'b1);
		t_bus;
		t_comb;
		t_kinds;
		t_clocks;
		t_async;
		t_io;
		t_reset;
		final_report;
	end
endmodule

`default_nettype wire
